/* rtl/otpp_pkg.sv */
// otp programming port: shared constants and types
// assumes a 200 MHz core clock on both ends
package otpp_pkg;
	// ==========================================================
	// geometry
	localparam int ADDR_W    = 15;
	localparam int DATA_W    = 8;
	localparam int MEM_BYTES = 32768;
	localparam int SIG_BYTES = 4;
	// ==========================================================
	// access modes
	typedef enum logic [1:0] {
		MODE_RSVD    = 2'h0,
		MODE_VERSION = 2'h1,
		MODE_LOCK    = 2'h2,
		MODE_MEM     = 2'h3
	} otpp_mode_t;
	// ==========================================================
	// lock levels on d1,d0
	localparam logic [1:0] LOCK_LVL0  = 2'h3;
	localparam logic [1:0] LOCK_LVL1  = 2'h2;
	localparam logic [1:0] LOCK_LVL2  = 2'h1;
	localparam logic [1:0] LOCK_LVL3  = 2'h0;
	localparam logic [1:0] LOCK_RESET = 2'h3;
	localparam logic [7:0] ERASED     = 8'hFF;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int WRITE_STROBE_A_TIME_US  = 100;
	localparam int WRITE_STROBE_A_CYCLES   = (WRITE_STROBE_A_TIME_US * 1000000) / CLK_PERIOD_PS;
	localparam int STROBE_CYCLES = 4;
endpackage

/* rtl/otpp_if.sv */
// otp programming port: pins between programmer and device
// the bench resolves the data bus from the two enables
`timescale 1ns/1ps
interface otpp_if;
	import otpp_pkg::*;
	logic              resetPin;
	logic              programStoreEn;
	logic              accessModeSelLo;
	logic              accessModeSelHi;
	logic              progAddrLatchStrobe;
	logic              progReadStrobeN;
	logic              writeStrobeAN;
	logic              accessOrProgVoltage;
	logic              progVoltageHigh;
	logic              basicModeSel;
	logic [7:0]        muxAddressPort;
	logic [DATA_W-1:0] devDataOut;
	logic              devDataOe;
	logic [DATA_W-1:0] hostDataOut;
	logic              hostDataOe;
	logic [DATA_W-1:0] dataIn;
	modport device (
		input  resetPin, programStoreEn, accessModeSelLo, accessModeSelHi,
		input  progAddrLatchStrobe, progReadStrobeN, writeStrobeAN,
		input  accessOrProgVoltage, progVoltageHigh, basicModeSel,
		input  muxAddressPort, dataIn,
		output devDataOut, devDataOe
	);
	modport host (
		output resetPin, programStoreEn, accessModeSelLo, accessModeSelHi,
		output progAddrLatchStrobe, progReadStrobeN, writeStrobeAN,
		output accessOrProgVoltage, progVoltageHigh, basicModeSel,
		output muxAddressPort, hostDataOut, hostDataOe,
		input  dataIn
	);
endinterface

/* rtl/otpp_device.sv */
// otp programming port: device end, otp store with lock bits
// assumes pins arrive asynchronously; core_clk stands for osc_input
//
// Contract
// - 32K byte store, byte programmed in 100us
// - programmer holds reset high throughout
// - programmer holds program store enable low
// - modes: 00 reserved, 01 version, 10 lock, 11 memory
// - mode lines stable before latch strobe rises
// - high address latched on strobe fall
// - read strobe controls all reads
// - write strobe for programming, low at entry
// - programming voltage high only while programming
// - data moves over bidirectional 8-bit port
// - basic mode entry precedes any access
// - lock bits set protection levels 0..3
// - version mode returns addressed signature byte
`timescale 1ns/1ps
module otpp_device
	import otpp_pkg::*;
#(
	parameter int          WRITE_STROBE_A_CNT = WRITE_STROBE_A_CYCLES,
	parameter logic [31:0] VERSION  = 32'hA5C3_1E07 // arbitrary value
)(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// pins
	otpp_if.device    pins,
	// status
	output logic      progBusy,
	output logic      progMode,
	output logic [1:0] lockLevel
);
	// ==========================================================
	// pin synchronisers
	// every pin crosses in through two flops before logic reads it
	localparam int NS = 14;
	logic [NS-1:0] syncA;
	logic [NS-1:0] syncB;
	logic [7:0]    addrA;
	logic [7:0]    addrB;
	logic [7:0]    dinA;
	logic [7:0]    dinB;
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			syncA <= '0;
			syncB <= '0;
			addrA <= 8'h00;
			addrB <= 8'h00;
			dinA  <= 8'h00;
			dinB  <= 8'h00;
		end
		else
		begin
			syncA <= {pins.resetPin, pins.programStoreEn, pins.accessModeSelHi,
				pins.accessModeSelLo, pins.progAddrLatchStrobe, pins.progReadStrobeN,
				pins.writeStrobeAN, pins.accessOrProgVoltage, pins.progVoltageHigh,
				pins.basicModeSel, 4'h0};
			syncB <= syncA;
			addrA <= pins.muxAddressPort;
			addrB <= addrA;
			dinA  <= pins.dataIn;
			dinB  <= dinA;
		end
	logic rstS, pseS, aleS, rdNS, wrNS, eaS, vppS, selS;
	otpp_mode_t modeS;
	assign rstS  = syncB[13];
	assign pseS  = syncB[12];
	assign modeS = otpp_mode_t'(syncB[11:10]);
	assign aleS  = syncB[9];
	assign rdNS  = syncB[8];
	assign wrNS  = syncB[7];
	assign eaS   = syncB[6];
	assign vppS  = syncB[5];
	assign selS  = syncB[4];
	// ==========================================================
	// entry into programming mode
	logic selPrev_reg;
	logic entry;
	// entry: reset high, store enable low, strobe and ea low, select rises
	assign entry = rstS && !pseS && !wrNS && !eaS && selS && !selPrev_reg;
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			selPrev_reg <= 1'b0;
		else
			selPrev_reg <= selS;
	// mode drops as soon as reset or store enable leaves its level
	logic active;
	assign active = progMode && rstS && !pseS;
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			progMode <= 1'b0;
		else if (!rstS || pseS)
			progMode <= 1'b0;
		else if (entry)
			progMode <= 1'b1;
	// ==========================================================
	// address latch, high part on strobe fall
	logic       alePrev_reg;
	logic [6:0] addrHi_reg;
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			alePrev_reg <= 1'b0;
			addrHi_reg  <= 7'h00;
		end
		else
		begin
			alePrev_reg <= aleS;
			if (alePrev_reg && !aleS)
				addrHi_reg <= addrB[6:0];
		end
	logic [ADDR_W-1:0] addr;
	assign addr = {addrHi_reg, addrB};
	// ==========================================================
	// storage
	logic [7:0] mem [MEM_BYTES];
	logic [1:0] lock_reg;
	assign lockLevel = lock_reg;
	logic       wrPrev_reg;
	logic       wrFall;
	assign wrFall = wrPrev_reg && !wrNS;
	logic [$clog2(WRITE_STROBE_A_CNT+1)-1:0] progCnt_reg;
	logic [ADDR_W-1:0] progAddr_reg;
	logic [7:0]        progData_reg;
	otpp_mode_t        progKind_reg;
	logic              progOk;
	// memory programming blocked at lock level 1 and above
	assign progOk = (modeS == MODE_LOCK) || (lock_reg == LOCK_LVL0);
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			wrPrev_reg   <= 1'b1;
			progBusy     <= 1'b0;
			progCnt_reg  <= '0;
			progAddr_reg <= '0;
			progData_reg <= 8'h00;
			progKind_reg <= MODE_RSVD;
			lock_reg     <= LOCK_RESET;
		end
		else
		begin
			wrPrev_reg <= wrNS;
			if (progBusy)
			begin
				if (progCnt_reg == '0)
				begin
					progBusy <= 1'b0;
					if (progKind_reg == MODE_LOCK)
						lock_reg <= lock_reg & progData_reg[1:0];
				end
				else
					progCnt_reg <= progCnt_reg - 1'b1;
			end
			// strobes that fall while busy are dropped
			else if (active && wrFall && vppS && eaS && progOk &&
				(modeS == MODE_MEM || modeS == MODE_LOCK))
			begin
				progBusy     <= 1'b1;
				progCnt_reg  <= ($clog2(WRITE_STROBE_A_CNT+1))'(WRITE_STROBE_A_CNT - 1);
				progAddr_reg <= addr;
				progData_reg <= dinB;
				progKind_reg <= modeS;
			end
		end
	// otp cells only clear bits; reset stands in for the erased state
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			mem <= '{default: ERASED};
		end
		else if (progBusy && progCnt_reg == '0 && progKind_reg == MODE_MEM)
		begin
			mem[progAddr_reg] <= mem[progAddr_reg] & progData_reg;
		end
	// ==========================================================
	// read path
	function automatic logic [7:0] versionByte(input logic [7:0] a);
		versionByte = VERSION[8*a[1:0] +: 8];
	endfunction
	logic       readEn;
	logic [7:0] rdData;
	// reads need ea high; the port stays released otherwise
	assign readEn = active && !rdNS && wrNS && eaS && !progBusy &&
		modeS != MODE_RSVD;
	always_comb
	begin
		rdData = 8'hFF;
		case (modeS)
			MODE_VERSION: rdData = versionByte(addrB);
			MODE_LOCK:    rdData = {6'h3F, lock_reg};
			// levels 2 and 3 hide memory from verify reads
			MODE_MEM:     rdData = (lock_reg == LOCK_LVL0 || lock_reg == LOCK_LVL1) ?
				mem[addr] : 8'hFF;
			default:      rdData = 8'hFF;
		endcase
	end
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			pins.devDataOe  <= 1'b0;
			pins.devDataOut <= 8'h00;
		end
		else
		begin
			pins.devDataOe  <= readEn;
			pins.devDataOut <= readEn ? rdData : 8'h00;
		end
endmodule

/* rtl/otpp_host.sv */
// otp programming port: programmer end, one command at a time
// assumes device end on the same core_clk
`timescale 1ns/1ps
module otpp_host
	import otpp_pkg::*;
#(
	parameter int STROBE = STROBE_CYCLES,
	parameter int WAIT   = WRITE_STROBE_A_CYCLES + 16
)(
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	// command
	input  wire logic                cmdValid,
	input  wire logic                cmdWrite,
	input  wire logic [1:0]          cmdMode,
	input  wire logic [ADDR_W-1:0]   cmdAddr,
	input  wire logic [DATA_W-1:0]   cmdData,
	output logic                     cmdReady,
	output logic                     rspValid,
	output logic [DATA_W-1:0]        rspData,
	// pins
	otpp_if.host                     pins
);
	typedef enum logic [7:0] {
		S_ENTRY = 8'h01, S_IDLE = 8'h02, S_MODE = 8'h04, S_ALEH = 8'h08,
		S_ALEL = 8'h10, S_LOW = 8'h20, S_STRB = 8'h40, S_DONE = 8'h80
	} otpp_hstate_t;
	otpp_hstate_t st_reg;
	logic [31:0]  cnt_reg;
	logic         wr_reg;
	logic [14:0]  addr_reg;
	logic [7:0]   data_reg;
	// ==========================================================
	// sequencer
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
		begin
			st_reg                   <= S_ENTRY;
			cnt_reg                  <= '0;
			wr_reg                   <= 1'b0;
			addr_reg                 <= '0;
			data_reg                 <= 8'h00;
			cmdReady                 <= 1'b0;
			rspValid                 <= 1'b0;
			rspData                  <= 8'h00;
			pins.resetPin            <= 1'b1;
			pins.programStoreEn      <= 1'b0;
			pins.accessModeSelLo     <= 1'b0;
			pins.accessModeSelHi     <= 1'b0;
			pins.progAddrLatchStrobe <= 1'b0;
			pins.progReadStrobeN     <= 1'b1;
			pins.writeStrobeAN       <= 1'b0;
			pins.accessOrProgVoltage <= 1'b0;
			pins.progVoltageHigh     <= 1'b0;
			pins.basicModeSel        <= 1'b0;
			pins.muxAddressPort      <= 8'h00;
			pins.hostDataOut         <= 8'h00;
			pins.hostDataOe          <= 1'b0;
		end
		else
		begin
			rspValid <= 1'b0;
			cnt_reg  <= cnt_reg + 1;
			case (st_reg)
				S_ENTRY:
				begin
					// strobe and ea low, then raise select
					if (cnt_reg == 32'(4 * STROBE))
						pins.basicModeSel <= 1'b1;
					if (cnt_reg == 32'(8 * STROBE))
					begin
						pins.writeStrobeAN       <= 1'b1;
						pins.accessOrProgVoltage <= 1'b1;
						st_reg                   <= S_IDLE;
						cmdReady                 <= 1'b1;
					end
				end
				S_IDLE:
					if (cmdValid)
					begin
						cmdReady             <= 1'b0;
						wr_reg               <= cmdWrite;
						addr_reg             <= cmdAddr;
						data_reg             <= cmdData;
						pins.accessModeSelLo <= cmdMode[0];
						pins.accessModeSelHi <= cmdMode[1];
						pins.muxAddressPort  <= {1'b0, cmdAddr[14:8]};
						cnt_reg              <= '0;
						st_reg               <= S_MODE;
					end
				S_MODE:
					if (cnt_reg == 32'(STROBE))
					begin
						pins.progAddrLatchStrobe <= 1'b1;
						cnt_reg                  <= '0;
						st_reg                   <= S_ALEH;
					end
				S_ALEH:
					if (cnt_reg == 32'(STROBE))
					begin
						pins.progAddrLatchStrobe <= 1'b0;
						cnt_reg                  <= '0;
						st_reg                   <= S_ALEL;
					end
				S_ALEL:
					if (cnt_reg == 32'(STROBE))
					begin
						pins.muxAddressPort  <= addr_reg[7:0];
						pins.hostDataOe      <= wr_reg;
						pins.hostDataOut     <= data_reg;
						pins.progVoltageHigh <= wr_reg;
						cnt_reg              <= '0;
						st_reg               <= S_LOW;
					end
				S_LOW:
					if (cnt_reg == 32'(STROBE))
					begin
						if (wr_reg)
							pins.writeStrobeAN <= 1'b0;
						else
							pins.progReadStrobeN <= 1'b0;
						cnt_reg <= '0;
						st_reg  <= S_STRB;
					end
				S_STRB:
					if (cnt_reg == 32'(2 * STROBE))
					begin
						pins.writeStrobeAN   <= 1'b1;
						pins.progReadStrobeN <= 1'b1;
						rspData              <= pins.dataIn;
						cnt_reg              <= '0;
						st_reg               <= S_DONE;
					end
				S_DONE:
					if (cnt_reg == (wr_reg ? 32'(WAIT) : 32'(STROBE)))
					begin
						pins.hostDataOe      <= 1'b0;
						pins.progVoltageHigh <= 1'b0;
						rspValid             <= 1'b1;
						cmdReady             <= 1'b1;
						st_reg               <= S_IDLE;
					end
				default:
					st_reg <= S_ENTRY;
			endcase
		end
endmodule

/* verif/otpp_checker.sv */
// otp programming port: pin protocol checker
// assumes instantiation beside the interface in the bench
`timescale 1ns/1ps
module otpp_checker
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// pins
	input wire logic resetPin,
	input wire logic programStoreEn,
	input wire logic accessModeSelLo,
	input wire logic accessModeSelHi,
	input wire logic progAddrLatchStrobe,
	input wire logic progReadStrobeN,
	input wire logic writeStrobeAN,
	input wire logic progVoltageHigh,
	input wire logic devDataOe,
	input wire logic hostDataOe
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// ==========================================================
	// host side
	property p_reset_held;
		resetPin;
	endproperty
	a_reset_held: assert property (p_reset_held)
		else $error("reset pin dropped");
	property p_store_en_low;
		!programStoreEn;
	endproperty
	a_store_en_low: assert property (p_store_en_low)
		else $error("store enable raised");
	property p_mode_hold;
		progAddrLatchStrobe && $past(progAddrLatchStrobe)
			|-> $stable({accessModeSelHi, accessModeSelLo});
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed while latch high");
	property p_mode_setup;
		$rose(progAddrLatchStrobe) |-> $stable({accessModeSelHi, accessModeSelLo});
	endproperty
	a_mode_setup: assert property (p_mode_setup)
		else $error("mode changed at latch rise");
	property p_read_not_write;
		!progReadStrobeN |-> writeStrobeAN;
	endproperty
	a_read_not_write: assert property (p_read_not_write)
		else $error("read and write strobes together");
	property p_vpp_not_read;
		progVoltageHigh |-> progReadStrobeN;
	endproperty
	a_vpp_not_read: assert property (p_vpp_not_read)
		else $error("high voltage during read");
	// ==========================================================
	// data bus
	property p_no_clash;
		!(devDataOe && hostDataOe);
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive data");
	property p_drive_in_read;
		$rose(devDataOe) |-> !progReadStrobeN;
	endproperty
	a_drive_in_read: assert property (p_drive_in_read)
		else $error("device drove data outside read");
	property p_release;
		$rose(progReadStrobeN) |-> ##[0:6] !devDataOe;
	endproperty
	a_release: assert property (p_release)
		else $error("device kept driving after read");
	c_write: cover property ($fell(writeStrobeAN) && progVoltageHigh);
	c_read: cover property ($rose(devDataOe));
	c_latch: cover property ($fell(progAddrLatchStrobe));
endmodule

/* verif/testbench.sv */
// otp programming port: bench driving the host command side
// assumes both ends share core_clk; short programming count
`timescale 1ns/1ps
module testbench
	import otpp_pkg::*;
;
	localparam int          PCNT = 50;
	localparam logic [31:0] VER  = 32'h1234_5678; // arbitrary value
	`define CHK(act, exp) \
	begin \
		comparisons++; \
		if ((act) !== (exp)) \
		begin \
			failCount++; \
			$display("Error at %0t: got %0h expected %0h", $time, act, exp); \
		end \
	end
	logic              core_clk;
	logic              arst_n;
	logic              cmdValid;
	logic              cmdWrite;
	logic [1:0]        cmdMode;
	logic [ADDR_W-1:0] cmdAddr;
	logic [DATA_W-1:0] cmdData;
	logic              cmdReady;
	logic              rspValid;
	logic [DATA_W-1:0] rspData;
	logic              progBusy;
	logic              progMode;
	logic [1:0]        lockLevel;
	logic [DATA_W-1:0] rd;
	int                failCount = 0;
	int                comparisons = 0;
	int                cycles = 0;
	logic [ADDR_W-1:0] addrTab [3] = '{15'h7FFF, 15'h0100, 15'h00FF};
	logic [DATA_W-1:0] dataTab [3] = '{8'h5A, 8'hC3, 8'h96};
	// ==========================================================
	// ends
	otpp_if ifc ();
	assign ifc.dataIn = ifc.devDataOe ? ifc.devDataOut : ifc.hostDataOe ? ifc.hostDataOut : 8'hFF;
	otpp_device #(.WRITE_STROBE_A_CNT(PCNT), .VERSION(VER)) i_otpp_device (.core_clk(core_clk),
		.arst_n(arst_n), .pins(ifc.device), .progBusy(progBusy), .progMode(progMode),
		.lockLevel(lockLevel));
	otpp_host #(.WAIT(PCNT + 16)) i_otpp_host (.core_clk(core_clk), .arst_n(arst_n),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdMode(cmdMode), .cmdAddr(cmdAddr),
		.cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
		.pins(ifc.host));
	otpp_checker i_otpp_checker (.core_clk(core_clk), .arst_n(arst_n),
		.resetPin(ifc.resetPin), .programStoreEn(ifc.programStoreEn),
		.accessModeSelLo(ifc.accessModeSelLo), .accessModeSelHi(ifc.accessModeSelHi),
		.progAddrLatchStrobe(ifc.progAddrLatchStrobe), .progReadStrobeN(ifc.progReadStrobeN),
		.writeStrobeAN(ifc.writeStrobeAN), .progVoltageHigh(ifc.progVoltageHigh),
		.devDataOe(ifc.devDataOe), .hostDataOe(ifc.hostDataOe));
	// ==========================================================
	// clock, timeout, verdict
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic wrap_up();
		if (failCount == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failCount++;
			wrap_up();
		end
	end
	// ==========================================================
	// one command through the host
	task automatic do_cmd(input logic wr, input logic [1:0] md, input logic [ADDR_W-1:0] ad,
		input logic [DATA_W-1:0] dt);
		int n;
		n = 0;
		while (cmdReady !== 1'b1 && n < 400)
		begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdWrite <= wr;
		cmdMode <= md;
		cmdAddr <= ad;
		cmdData <= dt;
		@(posedge core_clk);
		cmdValid <= 1'b0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (rspValid !== 1'b1 && n < 800);
		`CHK(rspValid, 1'b1)
		rd = rspData;
		if (wr)
			`CHK(progBusy, 1'b0)
	endtask
	// ==========================================================
	// sequence
	initial
	begin
		arst_n = 1'b0;
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdMode = 2'h0;
		cmdAddr = 15'h0000;
		cmdData = 8'h00;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		do_cmd(1'b0, MODE_VERSION, 15'h0000, 8'h00);
		`CHK(progMode, 1'b1)
		`CHK(lockLevel, LOCK_RESET)
		for (int i = 0; i < SIG_BYTES; i++)
		begin
			do_cmd(1'b0, MODE_VERSION, 15'(i), 8'h00);
			`CHK(rd, VER[8*i+:8])
		end
		do_cmd(1'b0, MODE_RSVD, 15'h0000, 8'h00);
		`CHK(rd, 8'hFF)
		for (int i = 0; i < 3; i++)
			do_cmd(1'b1, MODE_MEM, addrTab[i], dataTab[i]);
		for (int i = 0; i < 3; i++)
		begin
			do_cmd(1'b0, MODE_MEM, addrTab[i], 8'h00);
			`CHK(rd, dataTab[i])
		end
		do_cmd(1'b1, MODE_LOCK, 15'h0000, 8'hFE);
		`CHK(lockLevel, LOCK_LVL1)
		do_cmd(1'b0, MODE_LOCK, 15'h0000, 8'h00);
		`CHK(rd[1:0], LOCK_LVL1)
		do_cmd(1'b1, MODE_MEM, 15'h0100, 8'h00);
		do_cmd(1'b0, MODE_MEM, 15'h0100, 8'h00);
		`CHK(rd, 8'hC3)
		do_cmd(1'b1, MODE_LOCK, 15'h0000, 8'hFD);
		`CHK(lockLevel, LOCK_LVL3)
		do_cmd(1'b0, MODE_MEM, 15'h7FFF, 8'h00);
		`CHK(rd, ERASED)
		wrap_up();
	end
endmodule
